// File: rx_config_power_control.sv
// configuration, serial register port, sync detect and power control of the receiver
`timescale 1ns/10ps
`include "rx_cfg_consts.svh"

module rx_config_power_control
    import rx_cfg_pkg::*;
#(
    parameter int unsigned PIXEL_WIDTH         = 24,
    parameter int unsigned SYNC_TIMEOUT_CYCLES = `SYNC_TIMEOUT_NS / `CLK_PERIOD_NS
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   mode_select,
    input  wire logic                   output_clock_invert,
    input  wire logic                   pixel_per_clock_select,
    input  wire logic                   staggered_output_n,
    input  wire logic                   drive_strength_select_in,
    output wire logic                   drive_strength_select_out,
    output wire logic                   drive_strength_select_oe_n,
    input  wire logic                   hsync_dejitter_enable,
    input  wire logic                   output_power_down_n,
    input  wire logic                   power_down_n,
    input  wire video_type              video_in,
    input  wire logic [PIXEL_WIDTH-1:0] even_pixel_in,
    input  wire logic [PIXEL_WIDTH-1:0] odd_pixel_in,
    output wire logic                   pixel_clock_out,
    output wire logic [PIXEL_WIDTH-1:0] even_pixel_bus,
    output wire logic [PIXEL_WIDTH-1:0] odd_pixel_bus,
    output wire video_type              video_out,
    output wire logic                   data_oe_n,
    output wire logic                   gc1_oe_n,
    output wire logic                   sync_detect,
    output wire logic                   drive_high,
    output wire logic                   programmable_mode
);

    localparam int unsigned TW = $clog2(SYNC_TIMEOUT_CYCLES + 1);

    // register read decode
    function automatic logic [7:0] read_reg(input logic [7:0] idx, input cfg_type cfg,
                                            input logic sync, input logic prog);
        logic [7:0] val;
        val = 8'h00;
        if (idx == `CFG_REG_INDEX) begin
            val = {3'h0, cfg};
        end else if (idx == `STATUS_REG_INDEX) begin
            val[`STAT_SYNC_BIT] = sync;
            val[`STAT_PROG_BIT] = prog;
        end
        return val;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [7:0] sync1_ff, sync2_ff, sync3_ff;
    pins_type   pins_ff, nxt_pins;
    logic       prog;
    cfg_type    eff;

    // a bit changes only once stages two and three agree
    always_comb begin
        nxt_pins = pins_type'((sync2_ff & sync3_ff) | (pins_ff & (sync2_ff | sync3_ff)));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= `PIN_SYNC_RESET;
            sync2_ff <= `PIN_SYNC_RESET;
            sync3_ff <= `PIN_SYNC_RESET;
            pins_ff  <= pins_type'(`PIN_SYNC_RESET);
        end else begin
            sync1_ff <= {mode_select, output_clock_invert, pixel_per_clock_select, staggered_output_n,
                         drive_strength_select_in, hsync_dejitter_enable, output_power_down_n, power_down_n};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pins_ff  <= nxt_pins;
        end
    end

    // ****************************************************************
    // serial register port
    // ****************************************************************
    i2c_state_type state_ff, nxt_state;
    logic [3:0]    cnt_ff, nxt_cnt;
    logic [7:0]    shift_ff, nxt_shift, index_ff, nxt_index, rd_byte;
    logic          sda_oe_n_ff, nxt_sda_oe_n;
    cfg_type       cfg_ff, nxt_cfg;
    logic          scl_prev_ff, sda_prev_ff, i2c_on;
    logic          scl_rise, scl_fall, start_cond, stop_cond;
    logic          sync_ff;

    // both straps low select programmable mode
    assign prog       = !pins_ff.mode_sel && !pins_ff.stagger_n;
    // port only alive when not powered down
    assign i2c_on     = prog && pins_ff.pd_n;
    assign scl_rise   = pins_ff.clk_inv_scl && !scl_prev_ff;
    assign scl_fall   = !pins_ff.clk_inv_scl && scl_prev_ff;
    assign start_cond = pins_ff.clk_inv_scl && scl_prev_ff && sda_prev_ff && !pins_ff.drive_sda;
    assign stop_cond  = pins_ff.clk_inv_scl && scl_prev_ff && !sda_prev_ff && pins_ff.drive_sda;
    assign rd_byte    = read_reg(index_ff, cfg_ff, sync_ff, prog);

    // slave sequencer, one byte per transfer
    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_shift    = shift_ff;
        nxt_index    = index_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        nxt_cfg      = cfg_ff;
        if (!i2c_on) begin
            nxt_state    = I2C_IDLE;
            nxt_cnt      = 4'h0;
            nxt_sda_oe_n = 1'b1;
            nxt_cfg      = cfg_type'(`CFG_RESET);
        end else if (start_cond) begin
            nxt_state    = I2C_DEV;
            nxt_cnt      = 4'h0;
            nxt_sda_oe_n = 1'b1;
        end else if (stop_cond) begin
            nxt_state    = I2C_IDLE;
            nxt_sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            // scl only sampled, never held low
            if (state_ff == I2C_DEV || state_ff == I2C_IDX || state_ff == I2C_WR) begin
                nxt_shift = {shift_ff[6:0], pins_ff.drive_sda};
                nxt_cnt   = cnt_ff + 4'h1;
            end
        end else if (scl_fall) begin
            case (state_ff)
                I2C_DEV: begin
                    if (cnt_ff == `I2C_BITS_PER_BYTE) begin
                        nxt_cnt = 4'h0;
                        if (shift_ff[7:1] == `I2C_SLAVE_ADDR) begin
                            nxt_state    = I2C_DEV_ACK;
                            nxt_sda_oe_n = 1'b0;
                        end else begin
                            nxt_state = I2C_DONE;
                        end
                    end
                end
                I2C_DEV_ACK: begin
                    if (shift_ff[0]) begin
                        nxt_state    = I2C_RD;
                        nxt_sda_oe_n = rd_byte[7];
                        nxt_shift    = {rd_byte[6:0], 1'b1};
                        nxt_cnt      = 4'h1;
                    end else begin
                        nxt_state    = I2C_IDX;
                        nxt_sda_oe_n = 1'b1;
                    end
                end
                I2C_IDX: begin
                    if (cnt_ff == `I2C_BITS_PER_BYTE) begin
                        nxt_index    = shift_ff;
                        nxt_state    = I2C_IDX_ACK;
                        nxt_sda_oe_n = 1'b0;
                        nxt_cnt      = 4'h0;
                    end
                end
                I2C_IDX_ACK: begin
                    nxt_state    = I2C_WR;
                    nxt_sda_oe_n = 1'b1;
                end
                I2C_WR: begin
                    if (cnt_ff == `I2C_BITS_PER_BYTE) begin
                        if (index_ff == `CFG_REG_INDEX) begin
                            nxt_cfg = cfg_type'(shift_ff[4:0]);
                        end
                        nxt_state    = I2C_WR_ACK;
                        nxt_sda_oe_n = 1'b0;
                        nxt_cnt      = 4'h0;
                    end
                end
                I2C_WR_ACK: begin
                    nxt_state    = I2C_DONE;
                    nxt_sda_oe_n = 1'b1;
                end
                I2C_RD: begin
                    // sda driven low only, released for ones
                    if (cnt_ff == `I2C_BITS_PER_BYTE) begin
                        nxt_state    = I2C_RD_ACK;
                        nxt_sda_oe_n = 1'b1;
                    end else begin
                        nxt_sda_oe_n = shift_ff[7];
                        nxt_shift    = {shift_ff[6:0], 1'b1};
                        nxt_cnt      = cnt_ff + 4'h1;
                    end
                end
                I2C_RD_ACK: begin
                    nxt_state = I2C_DONE;
                end
                default: begin
                    nxt_state = state_ff;
                end
            endcase
        end
    end

    // port keeps running whatever the output power down pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= I2C_IDLE;
            cnt_ff      <= 4'h0;
            shift_ff    <= 8'h00;
            index_ff    <= 8'h00;
            sda_oe_n_ff <= 1'b1;
            cfg_ff      <= cfg_type'(`CFG_RESET);
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            shift_ff    <= nxt_shift;
            index_ff    <= nxt_index;
            sda_oe_n_ff <= nxt_sda_oe_n;
            cfg_ff      <= nxt_cfg;
            scl_prev_ff <= pins_ff.clk_inv_scl;
            sda_prev_ff <= pins_ff.drive_sda;
        end
    end

    // ****************************************************************
    // sync detect
    // ****************************************************************
    logic          de_prev_ff;
    logic [TW-1:0] tmo_ff, nxt_tmo;
    logic          nxt_sync;

    // timeout restarts on every data enable edge
    always_comb begin
        nxt_tmo  = tmo_ff;
        nxt_sync = sync_ff;
        if (!pins_ff.pd_n) begin
            nxt_tmo  = '0;
            nxt_sync = 1'b0;
        end else if (video_in.de != de_prev_ff) begin
            // toggling data enable means link alive
            nxt_tmo  = '0;
            nxt_sync = 1'b1;
        end else if (tmo_ff == TW'(SYNC_TIMEOUT_CYCLES - 1)) begin
            nxt_sync = 1'b0;
        end else begin
            nxt_tmo = tmo_ff + TW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            de_prev_ff <= 1'b0;
            tmo_ff     <= '0;
            sync_ff    <= 1'b0;
        end else begin
            de_prev_ff <= video_in.de;
            tmo_ff     <= nxt_tmo;
            sync_ff    <= nxt_sync;
        end
    end

    // ****************************************************************
    // output stage
    // ****************************************************************
    logic [PIXEL_WIDTH-1:0] even_ff, nxt_even, odd_ff, nxt_odd, odd_stage_ff, nxt_odd_stage;
    video_type              video_ff, nxt_video;
    logic [1:0]             phase_ff, nxt_phase;
    logic                   hs_hold_ff, nxt_hs_hold, pclk_phase_ff, nxt_pclk_phase;
    logic                   pclk_ff, nxt_pclk, data_oe_n_ff, nxt_data_oe_n, gc1_oe_n_ff, nxt_gc1_oe_n;
    logic                   drive_ff, prog_ff;

    // straps in compatible mode, registers otherwise
    assign eff = prog ? cfg_ff : cfg_type'{dejitter_on: pins_ff.dejitter, drive_high: pins_ff.drive_sda,
                                            stagger_n: pins_ff.stagger_n, two_pixel: pins_ff.pix_sel,
                                            clock_invert: pins_ff.clk_inv_scl};

    // everything cleared and released while powered down
    always_comb begin
        nxt_even       = '0;
        nxt_odd        = '0;
        nxt_odd_stage  = '0;
        nxt_video      = '0;
        nxt_phase      = 2'h0;
        nxt_hs_hold    = 1'b0;
        nxt_pclk_phase = 1'b0;
        nxt_pclk       = 1'b0;
        nxt_data_oe_n  = 1'b1;
        nxt_gc1_oe_n   = 1'b1;
        if (pins_ff.pd_n) begin
            // odd bus only carries data in two-pixel mode
            nxt_even      = even_pixel_in;
            nxt_odd_stage = eff.two_pixel ? odd_pixel_in : '0;
            // stagger approximated by one extra cycle on the odd bus
            nxt_odd       = (eff.two_pixel && !eff.stagger_n) ? odd_stage_ff : nxt_odd_stage;
            // data enable registered with the pixel data
            nxt_video     = video_in;
            // hsync snapped to a four-clock grid
            nxt_phase     = (video_in.de && !de_prev_ff) ? 2'h0 : phase_ff + 2'h1;
            nxt_hs_hold   = (phase_ff == `DEJITTER_PHASE_LAST) ? video_in.hsync : hs_hold_ff;
            nxt_video.hsync = eff.dejitter_on ? hs_hold_ff : video_in.hsync;
            // only the clock output sees the polarity
            nxt_pclk_phase = !pclk_phase_ff;
            nxt_pclk       = nxt_pclk_phase ^ eff.clock_invert;
            // output power down spares sync detect and control 1
            nxt_data_oe_n  = !pins_ff.out_pd_n;
            nxt_gc1_oe_n   = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            even_ff       <= '0;
            odd_ff        <= '0;
            odd_stage_ff  <= '0;
            video_ff      <= '0;
            phase_ff      <= 2'h0;
            hs_hold_ff    <= 1'b0;
            pclk_phase_ff <= 1'b0;
            pclk_ff       <= 1'b0;
            data_oe_n_ff  <= 1'b1;
            gc1_oe_n_ff   <= 1'b1;
            drive_ff      <= 1'b0;
            prog_ff       <= 1'b0;
        end else begin
            even_ff       <= nxt_even;
            odd_ff        <= nxt_odd;
            odd_stage_ff  <= nxt_odd_stage;
            video_ff      <= nxt_video;
            phase_ff      <= nxt_phase;
            hs_hold_ff    <= nxt_hs_hold;
            pclk_phase_ff <= nxt_pclk_phase;
            pclk_ff       <= nxt_pclk;
            data_oe_n_ff  <= nxt_data_oe_n;
            gc1_oe_n_ff   <= nxt_gc1_oe_n;
            drive_ff      <= pins_ff.pd_n && eff.drive_high;
            prog_ff       <= prog;
        end
    end

    // sync detect has no enable, always driven
    assign sync_detect                = sync_ff;
    assign drive_strength_select_out  = 1'b0;    // open drain, only ever pulls low
    assign drive_strength_select_oe_n = sda_oe_n_ff;
    assign pixel_clock_out            = pclk_ff;
    assign even_pixel_bus             = even_ff;
    assign odd_pixel_bus              = odd_ff;
    assign video_out                  = video_ff;
    assign data_oe_n                  = data_oe_n_ff;
    assign gc1_oe_n                   = gc1_oe_n_ff;
    assign drive_high                 = drive_ff;
    assign programmable_mode          = prog_ff;

endmodule // rx_config_power_control

// File: rx_cfg_consts.svh
// constants for the receiver configuration and power control block
`ifndef RX_CFG_CONSTS_SVH
`define RX_CFG_CONSTS_SVH

`define I2C_SLAVE_ADDR      7'h76
`define I2C_BITS_PER_BYTE   4'h8
`define CFG_REG_INDEX       8'h08
`define STATUS_REG_INDEX    8'h09
`define CFG_RESET           5'h0C
`define STAT_SYNC_BIT       0
`define STAT_PROG_BIT       1
`define PIN_SYNC_RESET      8'h00
`define DEJITTER_PHASE_LAST 2'h3
`define CLK_PERIOD_NS       10
`define SYNC_TIMEOUT_NS     100000

`endif

// File: rx_cfg_pkg.sv
// types shared by the receiver configuration and power control block
package rx_cfg_pkg;

    // synchronised configuration and power pins
    typedef struct packed {
        logic mode_sel;
        logic clk_inv_scl;
        logic pix_sel;
        logic stagger_n;
        logic drive_sda;
        logic dejitter;
        logic out_pd_n;
        logic pd_n;
    } pins_type;

    // operating configuration, also the layout of the config register
    typedef struct packed {
        logic dejitter_on;
        logic drive_high;
        logic stagger_n;
        logic two_pixel;
        logic clock_invert;
    } cfg_type;

    // video control signals travelling with the pixel data
    typedef struct packed {
        logic       de;
        logic       hsync;
        logic       vsync;
        logic [2:0] ctl;
    } video_type;

    // serial slave states, gray coded along the usual path
    typedef enum logic [3:0] {
        I2C_IDLE    = 4'h0,
        I2C_DEV     = 4'h1,
        I2C_DEV_ACK = 4'h3,
        I2C_IDX     = 4'h2,
        I2C_IDX_ACK = 4'h6,
        I2C_WR      = 4'h7,
        I2C_WR_ACK  = 4'h5,
        I2C_DONE    = 4'h4,
        I2C_RD      = 4'hC,
        I2C_RD_ACK  = 4'hD
    } i2c_state_type;

endpackage

// File: rx_cfg_checker_properties.sv
// port checks for the receiver configuration and power control block
`timescale 1ns/10ps
module rx_cfg_checker
    import rx_cfg_pkg::*;
#(
    parameter int unsigned PIXEL_WIDTH         = 24,
    parameter int unsigned SYNC_TIMEOUT_CYCLES = 20
) (
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   mode_select,
    input wire logic                   output_clock_invert,
    input wire logic                   pixel_per_clock_select,
    input wire logic                   staggered_output_n,
    input wire logic                   hsync_dejitter_enable,
    input wire logic                   output_power_down_n,
    input wire logic                   power_down_n,
    input wire video_type              video_in,
    input wire logic [PIXEL_WIDTH-1:0] even_pixel_in,
    input wire logic                   drive_strength_select_oe_n,
    input wire logic [PIXEL_WIDTH-1:0] even_pixel_bus,
    input wire logic [PIXEL_WIDTH-1:0] odd_pixel_bus,
    input wire video_type              video_out,
    input wire logic                   data_oe_n,
    input wire logic                   gc1_oe_n,
    input wire logic                   sync_detect,
    input wire logic                   programmable_mode
);
    // ****************
    // idle data enable
    // ****************
    logic        de_ff;
    logic        nxt_de;
    int unsigned idle_ff;
    int unsigned nxt_idle;
    // saturates so a long quiet link cannot wrap
    always_comb begin
        nxt_de = video_in.de;
        nxt_idle = (video_in.de != de_ff) ? 0 : (idle_ff > SYNC_TIMEOUT_CYCLES + 4) ? idle_ff : idle_ff + 1;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            de_ff <= 1'b0;
            idle_ff <= 0;
        end else begin
            de_ff <= nxt_de;
            idle_ff <= nxt_idle;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // [*8] covers the pin synchroniser
    property p_pd_quiet;
        !power_down_n [*8] |-> data_oe_n && gc1_oe_n && drive_strength_select_oe_n && !sync_detect;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("outputs live in power down");
    property p_ack_scl_low;
        $fell(drive_strength_select_oe_n) |-> !output_clock_invert;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("data pulled while clock high");
    property p_prog_entry;
        (!mode_select && !staggered_output_n && power_down_n) [*8] |-> programmable_mode;
    endproperty
    a_prog_entry: assert property (p_prog_entry) else $error("programmable mode missing");
    property p_odd_zero;
        (mode_select && !pixel_per_clock_select) [*8] |-> odd_pixel_bus == '0;
    endproperty
    a_odd_zero: assert property (p_odd_zero) else $error("odd bus live in one pixel mode");
    property p_data_lat;
        power_down_n [*8] |-> even_pixel_bus == $past(even_pixel_in) && video_out.de == $past(video_in.de);
    endproperty
    a_data_lat: assert property (p_data_lat) else $error("data or enable misaligned");
    property p_sync_rise;
        power_down_n [*8] ##0 $changed(video_in.de) |=> sync_detect;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync detect missed an edge");
    property p_sync_drop;
        idle_ff >= SYNC_TIMEOUT_CYCLES + 2 |-> !sync_detect;
    endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("sync detect held too long");
    property p_opd;
        !output_power_down_n [*8] |-> data_oe_n && (power_down_n ? !gc1_oe_n : 1'b1);
    endproperty
    a_opd: assert property (p_opd) else $error("output power down wrong");
    property p_hs_pass;
        (mode_select && !hsync_dejitter_enable && power_down_n) [*8] |-> video_out.hsync == $past(video_in.hsync);
    endproperty
    a_hs_pass: assert property (p_hs_pass) else $error("hsync not passed through");
endmodule // rx_cfg_checker

bind rx_config_power_control rx_cfg_checker #(.PIXEL_WIDTH(PIXEL_WIDTH), .SYNC_TIMEOUT_CYCLES(SYNC_TIMEOUT_CYCLES)) chk (
    .clk, .rst_b, .mode_select, .output_clock_invert, .pixel_per_clock_select, .staggered_output_n,
    .hsync_dejitter_enable,
    .output_power_down_n, .power_down_n, .video_in, .even_pixel_in, .drive_strength_select_oe_n,
    .even_pixel_bus, .odd_pixel_bus, .video_out, .data_oe_n, .gc1_oe_n, .sync_detect, .programmable_mode);

// File: i2c_host_model.sv
// two-wire bus host and board strap model facing the receiver
`timescale 1ns/10ps
module i2c_host_model #(
    parameter int H = 8
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ******************
    // bus and strap pins
    // ******************
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // move lines just after an edge, then hold them
    task automatic set(input logic c, input logic d, input int n);
        scl <= c;
        sda_low <= d;
        repeat (n) @(posedge clk);
    endtask
    task automatic pins(input logic c, input logic d);
        @(posedge clk);
        set(c, d, 1);
    endtask
    // data only moves while the clock is low
    task automatic bit_x(input logic b, output logic r);
        set(1'b0, !b, H);
        set(1'b1, !b, H);
        r = sda;
        set(1'b1, !b, H);
        set(1'b0, !b, H);
    endtask
    task automatic start();
        set(1'b0, 1'b0, H);
        set(1'b1, 1'b0, 2 * H);
        set(1'b1, 1'b1, 2 * H);
        set(1'b0, 1'b1, H);
    endtask
    task automatic stop();
        set(1'b0, 1'b1, H);
        set(1'b1, 1'b1, 2 * H);
        set(1'b1, 1'b0, 2 * H);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ack);
        logic k0, k1, k2;
        @(posedge clk);
        start();
        send({a, 1'b0}, k0);
        send(idx, k1);
        send(d, k2);
        stop();
        ack = k0 && k1 && k2;
    endtask
    // one byte read, host ends it without acknowledge
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        logic k;
        @(posedge clk);
        start();
        send(8'hEC, k);
        send(idx, k);
        start();
        send(8'hED, k);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(1'b1, k);
        stop();
    endtask
endmodule // i2c_host_model

// File: testbench.sv
// self-checking testbench for the receiver configuration and power control block
`timescale 1ns/10ps
module testbench;
    import rx_cfg_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode_select = 1'b1;
    logic        pixel_per_clock_select = 1'b0;
    logic        staggered_output_n = 1'b1;
    logic        hsync_dejitter_enable = 1'b0;
    logic        output_power_down_n = 1'b1;
    logic        power_down_n = 1'b1;
    logic        de_run = 1'b0;
    video_type   video_in = '0;
    logic [23:0] even_pixel_in = '0;
    logic [23:0] odd_pixel_in = '0;
    logic        scl, host_low, sda, drive_strength_select_out, drive_strength_select_oe_n, pixel_clock_out;
    logic [23:0] even_pixel_bus, odd_pixel_bus;
    video_type   video_out;
    logic        data_oe_n, gc1_oe_n, sync_detect, drive_high, programmable_mode;
    logic [23:0] exp_q[$];
    logic [23:0] got_q[$];
    event        got_ev;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // *****************
    // design and driver
    // *****************
    // open drain data line with a pull-up
    assign sda = !host_low && (drive_strength_select_oe_n || drive_strength_select_out);
    i2c_host_model host (.clk, .sda, .scl, .sda_low(host_low));
    rx_config_power_control #(.PIXEL_WIDTH(24), .SYNC_TIMEOUT_CYCLES(20)) uut (
        .clk, .rst_b, .mode_select, .output_clock_invert(scl), .pixel_per_clock_select, .staggered_output_n,
        .drive_strength_select_in(sda), .drive_strength_select_out, .drive_strength_select_oe_n,
        .hsync_dejitter_enable, .output_power_down_n, .power_down_n, .video_in, .even_pixel_in, .odd_pixel_in,
        .pixel_clock_out, .even_pixel_bus, .odd_pixel_bus, .video_out, .data_oe_n, .gc1_oe_n, .sync_detect,
        .drive_high, .programmable_mode);
    initial forever #5 clk = ~clk;
    // enable toggles while the link runs, controls wander
    always @(posedge clk) video_in <= {video_in.de ^ de_run, 5'($urandom)};
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            $display("wrong value at %0t: run timed out", $time);
            report_and_stop();
        end
    end
    // oldest expectation against each reported result
    initial forever begin
        @(got_ev);
        while (got_q.size() > 0) begin
            tests_run++;
            if (got_q[0] !== exp_q[0]) begin
                n_mismatch++;
                $display("wrong value at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
            end
            got_q.delete(0);
            exp_q.delete(0);
        end
    end
    task automatic chk(input logic [23:0] e, input logic [23:0] a);
        exp_q.push_back(e);
        got_q.push_back(a);
        ->got_ev;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        logic p0, k;
        logic [7:0] d;
        logic [23:0] v, w;
        void'($urandom(32'h4ef9a173));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        ticks(12);
        host.pins(1'b0, 1'b1);
        ticks(12);
        chk(24'h0, 24'({programmable_mode, drive_high}));
        p0 = pixel_clock_out;
        host.pins(1'b1, 1'b0);
        ticks(12);
        chk(24'({~p0, 1'b1}), 24'({pixel_clock_out, drive_high}));
        $display("test straps done");
        // one pixel, two together, two staggered
        for (int m = 0; m < 3; m++) begin
            w = 24'($urandom);
            v = 24'($urandom);
            @(posedge clk);
            pixel_per_clock_select <= m > 0;
            staggered_output_n <= m < 2;
            hsync_dejitter_enable <= m == 1;
            odd_pixel_in <= w;
            ticks(12);
            @(posedge clk);
            even_pixel_in <= v;
            odd_pixel_in <= ~w;
            ticks(1);
            chk(v, even_pixel_bus);
            chk(m == 0 ? 24'h0 : m == 1 ? ~w : w, odd_pixel_bus);
            ticks(1);
            chk(m == 0 ? 24'h0 : ~w, odd_pixel_bus);
        end
        $display("test pixels done");
        de_run <= 1'b1;
        ticks(10);
        chk(24'h1, 24'(sync_detect));
        @(posedge clk);
        output_power_down_n <= 1'b0;
        ticks(10);
        chk(24'h5, 24'({data_oe_n, gc1_oe_n, sync_detect}));
        @(posedge clk);
        output_power_down_n <= 1'b1;
        de_run <= 1'b0;
        ticks(40);
        chk(24'h0, 24'(sync_detect));
        $display("test sync done");
        @(posedge clk);
        mode_select <= 1'b0;
        staggered_output_n <= 1'b0;
        ticks(12);
        chk(24'h1, 24'(programmable_mode));
        host.wr(7'h76, 8'h08, 8'h03, k);
        ticks(4);
        chk(24'h2, 24'({k, drive_high}));
        host.rd(8'h08, d);
        chk(24'h03, 24'(d));
        host.rd(8'h09, d);
        chk(24'h02, 24'(d));
        host.wr(7'h77, 8'h08, 8'h10, k);
        chk(24'h0, 24'(k));
        @(posedge clk);
        output_power_down_n <= 1'b0;
        host.wr(7'h76, 8'h08, 8'h07, k);
        host.rd(8'h08, d);
        chk(24'h107, 24'({k, d}));
        @(posedge clk);
        output_power_down_n <= 1'b1;
        power_down_n <= 1'b0;
        ticks(10);
        host.wr(7'h76, 8'h08, 8'h01, k);
        chk(24'h0, 24'(k));
        @(posedge clk);
        power_down_n <= 1'b1;
        ticks(12);
        host.rd(8'h08, d);
        chk(24'h0C, 24'(d));
        $display("test serial and power done");
        ticks(2);
        report_and_stop();
    end
endmodule // testbench
